/* logic/btsq_pkg.sv */
`default_nettype none
package btsq_pkg;
  // register word addresses on the plain port
  localparam int          ADDR_W        = 7;
  localparam logic [6:0]  REG_CTRL      = 7'h00;
  localparam logic [6:0]  REG_STATUS    = 7'h01;
  localparam logic [6:0]  REG_IRQ_MASK  = 7'h02;
  localparam logic [6:0]  REG_CNT_LOAD  = 7'h03;
  localparam logic [6:0]  REG_SEQ       = 7'h04;
  localparam logic [6:0]  REG_TMR0      = 7'h05;
  localparam logic [6:0]  REG_TMR1      = 7'h06;
  localparam logic [6:0]  REG_TS_LO     = 7'h07;
  localparam logic [6:0]  REG_TS_HI     = 7'h08;
  localparam logic [6:0]  REG_TRC_PTR   = 7'h09;
  localparam logic [6:0]  REG_TRC_IDX   = 7'h0a;
  localparam logic [6:0]  REG_TRC_W0    = 7'h0b;
  localparam logic [6:0]  REG_TRC_W1    = 7'h0c;
  localparam logic [6:0]  REG_TRC_W2    = 7'h0d;
  localparam logic [6:0]  REG_TRC_W3    = 7'h0e;
  // per-state config block: 0x40 + state*8 + word
  localparam int          CFG_SEL_BIT   = 6;
  localparam int          CFG_WORDS     = 32;
  // word 0: addr_a [15:0], addr_b [31:16]
  // word 1: addr_mask [15:0], data_a [23:16], data_b [31:24]
  // word 2: data_mask [7:0], ext_val [15:8], ext_mask [23:16],
  //         cyc_en [26:24] (rd,wr,fetch), amode [28:27], dmode [30:29]
  // words 3..6: action slots
  localparam int          SLOT_BASE     = 3;
  localparam int          NUM_SLOTS     = 4;
  localparam int          NUM_STATES    = 4;
  // action slot fields
  localparam int          SL_EN         = 0;
  localparam int          SL_KIND_LO    = 1;
  localparam int          SL_USE_ADDR   = 4;
  localparam int          SL_USE_DATA   = 5;
  localparam int          SL_USE_CYC    = 6;
  localparam int          SL_USE_EXT    = 7;
  localparam int          SL_PARAM_LO   = 8;
  localparam int          SL_BPOP_LO    = 10;
  // action kinds
  localparam logic [2:0]  ACT_HALT_EVT  = 3'h0;
  localparam logic [2:0]  ACT_TRACE     = 3'h1;
  localparam logic [2:0]  ACT_JUMP      = 3'h2;
  localparam logic [2:0]  ACT_PTIMER    = 3'h3;
  localparam logic [2:0]  ACT_RSTART    = 3'h4;
  localparam logic [2:0]  ACT_RSTOP     = 3'h5;
  // halt_or_signal_action sub-operations
  localparam logic [1:0]  BP_HALT       = 2'h0;
  localparam logic [1:0]  BP_DEC        = 2'h1;
  localparam logic [1:0]  BP_NEXT       = 2'h2;
  localparam logic [1:0]  BP_INIT       = 2'h3;
  // qualifier compare modes
  localparam logic [1:0]  QM_POINT      = 2'h0;
  localparam logic [1:0]  QM_INCL       = 2'h1;
  localparam logic [1:0]  QM_EXCL       = 2'h2;
  // status bits
  localparam int          ST_HALT       = 0;
  localparam int          ST_JUMP       = 1;
  localparam int          ST_WRAP       = 2;
  localparam int          ST_W          = 3;
  // trace store
  localparam int          TRC_DEPTH     = 2047;
  localparam int          TRC_PTR_W     = 11;
  localparam logic [10:0] TRC_LAST      = 11'h7fe;
  localparam int          SAMPLE_W      = 104;
  localparam logic [15:0] CNT_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    BTSQ_S0,
    BTSQ_S1,
    BTSQ_S2,
    BTSQ_S3
  } btsq_state_e;

  // one target memory cycle as seen on the bus
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rd;
    logic        wr;
    logic        fetch;
    logic [7:0]  probe;
  } btsq_cyc_s;

  // one 104-bit history sample
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic [2:0]  cyc;
    logic [7:0]  probe;
    logic [1:0]  state;
    logic        halt;
    logic        evt;
    logic        jump;
    logic [63:0] stamp;
  } btsq_sample_s;
endpackage
`default_nettype wire

/* logic/btsq_top.sv */
// Functional notes
// - always exactly one of four sequencer states
// - up to four action slots per state
// - qualified event moves to another state
// - two address qualifiers as point matches
// - address range inclusive or exclusive
// - data qualifiers with same three modes
// - read, write, fetch types, any combination
// - eight probe lines compared to value
// - every compare has a bit mask
// - halt, count down, next or initial state
// - qualified cycles go into trace store
// - jump forces programmed target state
// - two timers started and stopped by actions
// - point timer: start addr A, stop B
// - range timer: separate start, stop actions
// - 2047 deep 104-bit circular trace store
// - free-running time stamp timer
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module btsq_top (
  input  wire logic                    clk_sys_i,   // 40 MHz system clock
  input  wire logic                    resetn_i,    // sync reset, active low
  input  wire btsq_pkg::btsq_cyc_s     cyc_i,       // monitored memory cycle
  input  wire logic [btsq_pkg::ADDR_W-1:0] reg_addr_i, // register word address
  input  wire logic [31:0]             reg_wdata_i, // write data
  input  wire logic                    reg_wr_i,    // write strobe
  input  wire logic                    reg_rd_i,    // read strobe
  output logic      [31:0]             reg_rdata_o, // read data, cycle after
  output logic                         halt_o,      // breakpoint pulse
  output logic      [1:0]              state_o,     // current sequencer state
  output logic                         irq_o        // level interrupt
);
  import btsq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state and storage
  logic [31:0]        cfg_q [0:CFG_WORDS-1];
  btsq_sample_s       trc_mem [0:TRC_DEPTH-1];
  btsq_state_e        state_q, state_d;
  logic               armed_q, armed_d;
  logic [15:0]        cnt_q, cnt_d, cnt_load_q, cnt_load_d;
  logic [1:0]         run_q, run_d;
  logic [31:0]        tmr_q [0:1];
  logic [31:0]        tmr_d [0:1];
  logic [63:0]        ts_q, ts_d;
  logic [10:0]        wptr_q, wptr_d, ridx_q, ridx_d;
  logic               full_q, full_d;
  logic [ST_W-1:0]    stat_q, stat_d, mask_q, mask_d;
  logic               halt_q, halt_d;
  logic [31:0]        rdata_q, rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // qualifier compare, masked bits drop out of both sides
  // ranges compare masked values too: masking low bits widens the window
  function automatic logic [2:0] qual(input logic [15:0] v, input logic [15:0] a,
                                      input logic [15:0] b, input logic [15:0] m,
                                      input logic [1:0] mode);
    logic [15:0] vm, am, bm;
    logic        ha, hb, hit;
    vm  = v & ~m;
    am  = a & ~m;
    bm  = b & ~m;
    ha  = (vm == am);
    hb  = (vm == bm);
    hit = 1'b0;
    case (mode)
      QM_POINT: hit = ha | hb;
      QM_INCL:  hit = (vm >= am) && (vm <= bm);
      QM_EXCL:  hit = (vm < am) || (vm > bm);
      default:  hit = 1'b0;
    endcase
    return {hit, ha, hb};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // the current state's parameters govern matching
  logic [31:0] w0, w1, w2;
  logic [2:0]  aq, dq;
  logic        cyc_hit, ext_hit;
  logic        eval;

  assign eval    = cyc_i.valid & armed_q;
  assign w0      = cfg_q[{state_q, 3'h0}];
  assign w1      = cfg_q[{state_q, 3'h1}];
  assign w2      = cfg_q[{state_q, 3'h2}];
  assign aq      = qual(cyc_i.addr, w0[15:0], w0[31:16], w1[15:0], w2[28:27]);
  assign dq      = qual({8'h00, cyc_i.data}, {8'h00, w1[23:16]}, {8'h00, w1[31:24]},
                        {8'hff, w2[7:0]}, w2[30:29]);
  // any enabled cycle type qualifies
  assign cyc_hit = |(w2[26:24] & {cyc_i.rd, cyc_i.wr, cyc_i.fetch});
  assign ext_hit = ((cyc_i.probe ^ w2[15:8]) & ~w2[23:16]) == 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // per-slot decode: each slot fires when its chosen qualifiers all hold
  logic [NUM_SLOTS-1:0] fire;
  logic [2:0]           kind  [0:NUM_SLOTS-1];
  logic [1:0]           param [0:NUM_SLOTS-1];
  logic [1:0]           bpop  [0:NUM_SLOTS-1];

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      logic [31:0] sl;
      assign sl       = cfg_q[{state_q, 3'(SLOT_BASE + g)}];
      assign kind[g]  = sl[SL_KIND_LO +: 3];
      assign param[g] = sl[SL_PARAM_LO +: 2];
      assign bpop[g]  = sl[SL_BPOP_LO +: 2];
      assign fire[g]  = eval & sl[SL_EN]
                      & (~sl[SL_USE_ADDR] | aq[2])
                      & (~sl[SL_USE_DATA] | dq[2])
                      & (~sl[SL_USE_CYC]  | cyc_hit)
                      & (~sl[SL_USE_EXT]  | ext_hit);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // combine slot results; any jump beats next/initial, else lowest slot wins when two want a state change
  logic        trc_hit, jmp_fire, bp_halt, bp_dec, bp_any;
  logic        mv_fire;
  btsq_state_e mv_tgt;
  logic [1:0]  t_start, t_stop;

  always_comb begin
    trc_hit  = 1'b0;
    jmp_fire = 1'b0;
    bp_halt  = 1'b0;
    bp_dec   = 1'b0;
    bp_any   = 1'b0;
    mv_fire  = 1'b0;
    mv_tgt   = state_q;
    t_start  = 2'b00;
    t_stop   = 2'b00;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (fire[k]) begin
        case (kind[k])
          ACT_TRACE: trc_hit = 1'b1;
          ACT_JUMP: begin
            jmp_fire = 1'b1;
            mv_fire  = 1'b1;
            mv_tgt   = btsq_state_e'(param[k]);
          end
          ACT_HALT_EVT: begin
            bp_any = 1'b1;
            if (bpop[k] == BP_HALT) bp_halt = 1'b1;
            if (bpop[k] == BP_DEC) bp_dec = 1'b1;
          end
          ACT_PTIMER: begin
            // start on the first address, stop on the second
            if (aq[1]) t_start[param[k][0]] = 1'b1;
            if (aq[0]) t_stop[param[k][0]]  = 1'b1;
          end
          ACT_RSTART: t_start[param[k][0]] = 1'b1;
          ACT_RSTOP:  t_stop[param[k][0]]  = 1'b1;
          default: ;
        endcase
      end
    end
    // next/initial only when no jump already claimed the state change
    if (!jmp_fire) begin
      for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
        if (fire[k] && kind[k] == ACT_HALT_EVT && bpop[k] == BP_NEXT) begin
          mv_fire = 1'b1;
          case (state_q)
            BTSQ_S0: mv_tgt = BTSQ_S1;
            BTSQ_S1: mv_tgt = BTSQ_S2;
            BTSQ_S2: mv_tgt = BTSQ_S3;
            default: mv_tgt = BTSQ_S0;
          endcase
        end
        if (fire[k] && kind[k] == ACT_HALT_EVT && bpop[k] == BP_INIT) begin
          mv_fire = 1'b1;
          mv_tgt  = BTSQ_S0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer, counter, timers and trace pointer next values
  logic arm_wr, sw_wr, trc_write;

  assign arm_wr    = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[0];
  assign sw_wr     = reg_wr_i && reg_addr_i == REG_CTRL && !reg_wdata_i[0];
  assign trc_write = trc_hit;

  always_comb begin
    state_d    = state_q;
    armed_d    = armed_q;
    cnt_d      = cnt_q;
    cnt_load_d = cnt_load_q;
    run_d      = run_q;
    tmr_d[0]   = tmr_q[0];
    tmr_d[1]   = tmr_q[1];
    ts_d       = ts_q + 64'h1;
    wptr_d     = wptr_q;
    full_d     = full_q;
    halt_d     = bp_halt;
    if (bp_dec && cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
      // count expiry halts the target
      if (cnt_q == 16'h0001) halt_d = 1'b1;
    end
    if (mv_fire) state_d = mv_tgt;
    for (int t = 0; t < 2; t++) begin
      if (run_q[t]) tmr_d[t] = tmr_q[t] + 32'h1;
      if (t_start[t]) run_d[t] = 1'b1;
      if (t_stop[t]) run_d[t] = 1'b0;
    end
    if (trc_write) begin
      // oldest sample is overwritten once the store wraps
      wptr_d = (wptr_q == TRC_LAST) ? 11'h000 : wptr_q + 11'h001;
      if (wptr_q == TRC_LAST) full_d = 1'b1;
    end
    if (reg_wr_i && reg_addr_i == REG_CNT_LOAD) cnt_load_d = reg_wdata_i[15:0];
    if (sw_wr) armed_d = 1'b0;
    if (arm_wr) begin
      armed_d  = 1'b1;
      state_d  = BTSQ_S0;
      run_d    = 2'b00;
      tmr_d[0] = 32'h0;
      tmr_d[1] = 32'h0;
      cnt_d    = cnt_load_q;
      wptr_d   = 11'h000;
      full_d   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q    <= BTSQ_S0;
      armed_q    <= 1'b0;
      cnt_q      <= CNT_RESET;
      cnt_load_q <= CNT_RESET;
      run_q      <= 2'b00;
      tmr_q[0]   <= 32'h0;
      tmr_q[1]   <= 32'h0;
      ts_q       <= 64'h0;
      wptr_q     <= 11'h000;
      full_q     <= 1'b0;
      halt_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      armed_q    <= armed_d;
      cnt_q      <= cnt_d;
      cnt_load_q <= cnt_load_d;
      run_q      <= run_d;
      tmr_q[0]   <= tmr_d[0];
      tmr_q[1]   <= tmr_d[1];
      ts_q       <= ts_d;
      wptr_q     <= wptr_d;
      full_q     <= full_d;
      halt_q     <= halt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trace store and config array; no reset, contents are don't-care
  btsq_sample_s smp;
  always_comb begin
    smp.addr  = cyc_i.addr;
    smp.data  = cyc_i.data;
    smp.cyc   = {cyc_i.rd, cyc_i.wr, cyc_i.fetch};
    smp.probe = cyc_i.probe;
    smp.state = state_q;
    smp.halt  = bp_halt;
    smp.evt   = bp_any;
    smp.jump  = jmp_fire;
    smp.stamp = ts_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (trc_write) trc_mem[wptr_q] <= smp;
    if (reg_wr_i && reg_addr_i[CFG_SEL_BIT]) cfg_q[reg_addr_i[4:0]] <= reg_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // status, mask, read port; set beats a same-cycle write-one clear
  logic [ST_W-1:0] ev;
  logic [SAMPLE_W-1:0] rsmp;
  assign ev   = {trc_write && wptr_q == TRC_LAST, mv_fire, halt_d};
  assign rsmp = trc_mem[ridx_q];

  always_comb begin
    stat_d  = stat_q;
    mask_d  = mask_q;
    ridx_d  = ridx_q;
    rdata_d = 32'h0;
    if (reg_wr_i && reg_addr_i == REG_STATUS) stat_d = stat_q & ~reg_wdata_i[ST_W-1:0];
    stat_d = stat_d | ev;
    if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) mask_d = reg_wdata_i[ST_W-1:0];
    if (reg_wr_i && reg_addr_i == REG_TRC_IDX) ridx_d = reg_wdata_i[10:0];
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:     rdata_d = {31'h0, armed_q};
        REG_STATUS:   rdata_d = {29'h0, stat_q};
        REG_IRQ_MASK: rdata_d = {29'h0, mask_q};
        REG_CNT_LOAD: rdata_d = {16'h0, cnt_load_q};
        REG_SEQ:      rdata_d = {cnt_q, 12'h0, run_q, state_q};
        REG_TMR0:     rdata_d = tmr_q[0];
        REG_TMR1:     rdata_d = tmr_q[1];
        REG_TS_LO:    rdata_d = ts_q[31:0];
        REG_TS_HI:    rdata_d = ts_q[63:32];
        REG_TRC_PTR:  rdata_d = {15'h0, full_q, 5'h0, wptr_q};
        REG_TRC_IDX:  rdata_d = {21'h0, ridx_q};
        REG_TRC_W0:   rdata_d = rsmp[31:0];
        REG_TRC_W1:   rdata_d = rsmp[63:32];
        REG_TRC_W2:   rdata_d = rsmp[95:64];
        REG_TRC_W3:   rdata_d = {24'h0, rsmp[103:96]};
        default: rdata_d = reg_addr_i[CFG_SEL_BIT] ? cfg_q[reg_addr_i[4:0]] : 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      stat_q  <= '0;
      mask_q  <= '0;
      ridx_q  <= 11'h000;
      rdata_q <= 32'h0;
    end else begin
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      ridx_q  <= ridx_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign halt_o      = halt_q;
  assign state_o     = state_q;
  assign irq_o       = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  chk_arm_clears: assert property (arm_wr |=> state_q == BTSQ_S0 && run_q == 2'b00)
    else $error("arming did not reset sequencer");
  chk_count_halt: assert property (bp_dec && cnt_q == 16'h0001 && !arm_wr |=> halt_o)
    else $error("count expiry did not halt");
  chk_jump_target: assert property (jmp_fire && !arm_wr |=> state_q == $past(mv_tgt))
    else $error("jump went to wrong state");
  chk_idle_hold: assert property (!cyc_i.valid && !reg_wr_i |=> $stable(state_q))
    else $error("state moved without a memory cycle");
  chk_trace_adv: assert property (trc_write && !arm_wr && wptr_q != TRC_LAST
                                  |=> wptr_q == $past(wptr_q) + 11'h001)
    else $error("trace pointer did not advance");
  chk_trace_wrap: assert property (wptr_q <= TRC_LAST)
    else $error("trace pointer beyond store");
  // the release edge has no earlier stamp to compare with
  chk_ts_free: assert property ($past(resetn_i) |-> ts_q == $past(ts_q) + 64'h1)
    else $error("time stamp not free running");
  chk_tmr_count: assert property (run_q[0] && !arm_wr
                                  |=> tmr_q[0] == $past(tmr_q[0]) + 32'h1)
    else $error("running timer did not count");
  // stop wins over start, so only an unopposed start is checked
  chk_ptimer_start: assert property (fire[0] && kind[0] == ACT_PTIMER && aq[1]
                                     && !t_stop[param[0][0]] && !arm_wr |=> run_q[param[0][0]])
    else $error("point timer did not start");
  // a state change must reach the pin when its bit is unmasked
  chk_irq_level: assert property (mv_fire && mask_q[ST_JUMP] && !reg_wr_i |=> irq_o)
    else $error("interrupt level mismatch");

  cov_jump:  cover property (jmp_fire ##1 state_q != BTSQ_S0);
  cov_wrap:  cover property (trc_write && wptr_q == TRC_LAST);
  cov_halt:  cover property (halt_o);
  cov_timer: cover property (t_start[1] ##[1:20] t_stop[1]);
endmodule // btsq_top
`default_nettype wire

/* test/btsq_tgt_model.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// target memory bus plus probe lines, one queued cycle per valid beat
module btsq_tgt_model (
  input  wire logic           clk_i,  // system clock
  input  wire logic           slow_i, // idle gaps between cycles
  output var btsq_pkg::btsq_cyc_s cyc_o   // memory cycle toward the unit
);
  import btsq_pkg::*;
  btsq_cyc_s q[$];
  btsq_cyc_s last;
  btsq_cyc_s idle;
  int        gap;

  initial begin
    last  = '0;
    gap   = 0;
  end

  task automatic issue(input btsq_cyc_s c);
    q.push_back(c);
  endtask

  // between cycles the lines carry the inverse of the last beat,
  // so a stale value can never match a qualifier by luck
  always @(posedge clk_i) begin
    if (q.size() != 0 && gap == 0) begin
      last = q.pop_front();
      cyc_o <= last;
      gap = slow_i ? 2 : 0;
    end else begin
      idle = ~last;
      idle.valid = 1'b0;
      cyc_o <= idle;
      if (gap > 0) gap = gap - 1;
    end
  end
endmodule // btsq_tgt_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import btsq_pkg::*;
  localparam logic [15:0] CA [4] = '{16'h1000, 16'h2000, 16'h0fff, 16'h2001};
  localparam logic [7:0]  CD [4] = '{8'h40, 8'h80, 8'h3f, 8'h81};
  localparam logic [15:0] TA [4] = '{16'h0200, 16'h0400, 16'h0300, 16'h0400};
  localparam logic [7:0]  TD [4] = '{8'h00, 8'h11, 8'h00, 8'h00};
  localparam logic [7:0]  TP [4] = '{8'h00, 8'h00, 8'h00, 8'h5a};
  localparam logic [1:0]  TR [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  logic        clk_sys;
  logic        resetn;
  logic [6:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdat, t0;
  logic        reg_wr, reg_rd, slow, halt, irq, ex;
  logic [1:0]  state;
  logic [15:0] seed, va, am;
  logic [7:0]  vd, dm, p;
  btsq_cyc_s   cyc;
  int          err_count, total_checks, i, md, q, en, t;

  btsq_top dut_u (.clk_sys_i(clk_sys), .resetn_i(resetn), .cyc_i(cyc), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .halt_o(halt), .state_o(state), .irq_o(irq));
  btsq_tgt_model tgt_u (.clk_i(clk_sys), .slow_i(slow), .cyc_o(cyc));

  always #12.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // mask bit 1 drops the bit; ranges are taken unmasked here
  function automatic logic qm(input logic [15:0] v, a, b, m, input int md);
    case (md)
      0: return ((v & ~m) == (a & ~m)) || ((v & ~m) == (b & ~m));
      1: return (v >= a) && (v <= b);
      default: return (v < a) || (v > b);
    endcase
  endfunction
  function automatic logic [31:0] slot(input logic [2:0] k, input logic [3:0] u,
                                       input logic [1:0] pr, op);
    return {20'h0, op, pr, u, k, 1'b1};
  endfunction
  function automatic btsq_cyc_s mk(input logic [15:0] a, input logic [7:0] d,
                                   input logic [2:0] ty, input logic [7:0] pb);
    return '{valid: 1'b1, addr: a, data: d, rd: ty[2], wr: ty[1], fetch: ty[0], probe: pb};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [6:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rdat = reg_rdata;
  endtask
  task automatic cfg(input logic [1:0] s, input logic [2:0] w, input logic [31:0] d);
    wr(7'h40 | {2'b00, s, w}, d);
  endtask
  // queue one beat, then wait until n beats were taken by the unit
  task automatic mem(input btsq_cyc_s cv, input int n);
    int k;
    tgt_u.issue(cv);
    k = 0;
    while (k < n) begin
      @(posedge clk_sys);
      if (cyc.valid === 1'b1) k++;
    end
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // generous bound, the longest stretch is the trace wrap
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    err_count = 0;
    total_checks = 0;
    seed = 16'ha43e;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    `CHK("state", 2'h0, state)
    rd(REG_CTRL);
    `CHK("ctrl", 32'h0, rdat)
    rd(7'h3f);
    `CHK("unmapped", 32'h0, rdat)
    for (i = 0; i < 16; i++) cfg(2'(i / 4), 3'(3 + i % 4), 32'h0);
    wr(REG_CTRL, 32'h1);
    $display("test reset done");
    // address and data qualifiers in every mode, corners then random
    cfg(2'h0, 3'h0, 32'h2000_1000);
    for (md = 0; md < 3; md++) for (q = 0; q < 2; q++) begin
      am = (md == 0) ? 16'h000f : 16'h0;
      dm = (md == 0) ? 8'h03 : 8'h0;
      cfg(2'h0, 3'h1, {8'h80, 8'h40, am});
      cfg(2'h0, 3'h2, {1'b0, 2'(md), 2'(md), 19'h0, dm});
      cfg(2'h0, 3'h3, slot(ACT_HALT_EVT, q ? 4'h2 : 4'h1, 2'h0, BP_HALT));
      for (i = 0; i < 24; i++) begin
        seed = lfsr(seed);
        va = (i < 4) ? CA[i] : 16'h0f00 + (seed & 16'h13ff);
        vd = (i < 4) ? CD[i] : seed[7:0];
        slow <= seed[0];
        mem(mk(va, vd, 3'h4, 8'h0), 1);
        ex = q ? qm({8'h0, vd}, 16'h40, 16'h80, {8'h0, dm}, md)
               : qm(va, 16'h1000, 16'h2000, am, md);
        `CHK("halt qualifier", ex, halt)
      end
    end
    $display("test qualifiers done");
    // every nonempty combination of enabled cycle types against each type
    cfg(2'h0, 3'h3, slot(ACT_HALT_EVT, 4'h4, 2'h0, BP_HALT));
    for (en = 1; en < 8; en++) begin
      cfg(2'h0, 3'h2, {5'h0, 3'(en), 24'h0});
      for (t = 0; t < 3; t++) begin
        mem(mk(16'h5555, 8'h0, 3'(1 << t), 8'h0), 1);
        `CHK("halt cycle", |(3'(en) & 3'(1 << t)), halt)
      end
    end
    // probe lines, low nibble masked away
    cfg(2'h0, 3'h2, {8'h0, 8'h0f, 8'ha5, 8'h0});
    cfg(2'h0, 3'h3, slot(ACT_HALT_EVT, 4'h8, 2'h0, BP_HALT));
    for (i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      p = {seed[0] ? 4'ha : seed[7:4], seed[11:8]};
      mem(mk(16'h5555, 8'h0, 3'h4, p), 1);
      `CHK("halt probe", ((p ^ 8'ha5) & 8'hf0) == 8'h0, halt)
    end
    $display("test types done");
    // chained jumps on back to back cycles, status and interrupt
    slow <= 1'b0;
    cfg(2'h0, 3'h0, 32'h0000_0100);
    cfg(2'h0, 3'h1, 32'h0);
    cfg(2'h0, 3'h2, 32'h0);
    cfg(2'h0, 3'h3, slot(ACT_JUMP, 4'h1, 2'h1, 2'h0));
    cfg(2'h1, 3'h3, slot(ACT_JUMP, 4'h0, 2'h3, 2'h0));
    wr(REG_STATUS, 32'h7);
    wr(REG_IRQ_MASK, 32'h1 << ST_JUMP);
    mem(mk(16'h0101, 8'h0, 3'h4, 8'h0), 1);
    `CHK("no jump", 2'h0, state)
    `CHK("irq idle", 1'b0, irq)
    tgt_u.issue(mk(16'h0100, 8'h0, 3'h1, 8'h0));
    mem(mk(16'h0777, 8'h0, 3'h4, 8'h0), 2);
    `CHK("two jumps", 2'h3, state)
    `CHK("irq set", 1'b1, irq)
    rd(REG_STATUS);
    `CHK("status jump", 1'b1, rdat[ST_JUMP])
    wr(REG_IRQ_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(REG_IRQ_MASK, 32'h1 << ST_JUMP);
    wr(REG_STATUS, 32'h1 << ST_JUMP);
    `CHK("irq cleared", 1'b0, irq)
    $display("test jumps done");
    // next, count down to a halt, then back to the initial state
    cfg(2'h0, 3'h3, slot(ACT_HALT_EVT, 4'h0, 2'h0, BP_NEXT));
    cfg(2'h1, 3'h3, slot(ACT_HALT_EVT, 4'h0, 2'h0, BP_DEC));
    wr(REG_CNT_LOAD, 32'h2);
    wr(REG_CTRL, 32'h1);
    rd(REG_SEQ);
    `CHK("arm seq", 32'h0002_0000, rdat)
    mem(mk(16'h0100, 8'h0, 3'h4, 8'h0), 1);
    `CHK("next", 2'h1, state)
    mem(mk(16'h0100, 8'h0, 3'h4, 8'h0), 1);
    `CHK("count 1", 1'b0, halt)
    mem(mk(16'h0100, 8'h0, 3'h4, 8'h0), 1);
    `CHK("count 0", 1'b1, halt)
    rd(REG_SEQ);
    `CHK("counter", 16'h0, rdat[31:16])
    cfg(2'h1, 3'h3, slot(ACT_HALT_EVT, 4'h0, 2'h0, BP_INIT));
    mem(mk(16'h0100, 8'h0, 3'h4, 8'h0), 1);
    `CHK("initial", 2'h0, state)
    wr(REG_CTRL, 32'h0);
    mem(mk(16'h0100, 8'h0, 3'h4, 8'h0), 1);
    `CHK("disarmed", 2'h0, state)
    $display("test events done");
    // point timer on timer0, range start and stop on timer1
    cfg(2'h0, 3'h0, 32'h0300_0200);
    cfg(2'h0, 3'h1, 32'h1111_0000);
    cfg(2'h0, 3'h2, 32'h0000_5a00);
    cfg(2'h0, 3'h3, slot(ACT_PTIMER, 4'h0, 2'h0, 2'h0));
    cfg(2'h0, 3'h4, slot(ACT_RSTART, 4'h2, 2'h1, 2'h0));
    cfg(2'h0, 3'h5, slot(ACT_RSTOP, 4'h8, 2'h1, 2'h0));
    wr(REG_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      mem(mk(TA[i], TD[i], 3'h4, TP[i]), 1);
      rd(REG_SEQ);
      `CHK("timer run", TR[i], rdat[3:2])
    end
    rd(REG_TMR0);
    t0 = rdat;
    rd(REG_TMR0);
    `CHK("timer held", t0, rdat)
    `CHK("timer counted", 1'b1, t0 != 32'h0)
    rd(REG_TS_LO);
    t0 = rdat;
    rd(REG_TS_LO);
    `CHK("stamp runs", 1'b1, rdat > t0)
    wr(REG_CTRL, 32'h1);
    rd(REG_TMR0);
    `CHK("timer cleared", 32'h0, rdat)
    $display("test timers done");
    // trace writes only, then fill the store until it wraps
    cfg(2'h0, 3'h2, {5'h0, 3'b010, 24'h0});
    cfg(2'h0, 3'h3, slot(ACT_TRACE, 4'h4, 2'h0, 2'h0));
    cfg(2'h0, 3'h4, 32'h0);
    cfg(2'h0, 3'h5, 32'h0);
    wr(REG_CTRL, 32'h1);
    mem(mk(16'h1111, 8'h22, 3'h4, 8'h0), 1);
    mem(mk(16'h1234, 8'h56, 3'h2, 8'h3c), 1);
    rd(REG_TRC_PTR);
    `CHK("trace ptr", 32'h1, rdat)
    wr(REG_TRC_IDX, 32'h0);
    rd(REG_TRC_W3);
    `CHK("sample hi", 32'h12, rdat)
    rd(REG_TRC_W2);
    `CHK("sample w2", {8'h34, 8'h56, 3'b010, 8'h3c}, rdat[31:5])
    for (i = 0; i < 2045; i++) tgt_u.issue(mk(16'h4400, 8'h0, 3'h2, 8'h0));
    mem(mk(16'h4400, 8'h0, 3'h2, 8'h0), 2046);
    rd(REG_TRC_PTR);
    `CHK("wrapped", 32'h0001_0000, rdat)
    rd(REG_STATUS);
    `CHK("status wrap", 1'b1, rdat[ST_WRAP])
    mem(mk(16'h7700, 8'h0, 3'h2, 8'h0), 1);
    rd(REG_TRC_W3);
    `CHK("oldest replaced", 32'h77, rdat)
    $display("test trace done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
